// File: design/cbl_bus_seq.v
// Bus-cycle sequencer: fetches opcodes and operands, forms addresses, runs one bus cycle per clock.
// Assumes single-cycle memory: rdata_i holds the byte of the read issued in the previous cycle.
`timescale 1ns/1ps
`include "cbl_defs.vh"
module cbl_bus_seq
(
    input  wire        clk_sys_i,
    input  wire        srst_i,
    input  wire [7:0]  rdata_i,
    input  wire        irq_i,
    input  wire [7:0]  vec_lo_i,
    input  wire        push_req_i,
    input  wire        pop_req_i,
    input  wire [7:0]  push_data_i,
    input  wire [7:0]  wr_data_i,
    input  wire        take_branch_i,
    output reg  [15:0] addr_o,
    output reg  [7:0]  wdata_o,
    output reg         rd_o,
    output reg         wr_o,
    output reg  [2:0]  cyc_kind_o,
    output reg  [7:0]  opcode_o,
    output reg         page2_o,
    output reg  [3:0]  mode_o,
    output reg  [15:0] ea_o,
    output reg  [15:0] pc_o,
    output reg  [15:0] index_o,
    output reg  [15:0] sp_o,
    output reg  [7:0]  pop_data_o,
    output reg         pop_valid_o,
    output reg         instr_done_o
);
    localparam ST_VEC_HI = 3'h0;
    localparam ST_VEC_LO = 3'h1;
    localparam ST_OPCODE = 3'h2;
    localparam ST_OPND   = 3'h3;
    localparam ST_EXEC   = 3'h4;
    localparam ST_DATA   = 3'h5;
    localparam ST_FREE   = 3'h6;
    localparam ST_FETCH0 = 3'h7;

    reg  [2:0]  state_q;
    reg  [2:0]  state_d;
    reg  [15:0] opnd_q;
    reg  [1:0]  left_q;
    reg         pfx_q;
    reg         pop_pend_q;
    reg  [15:0] vec_q;
    wire [3:0]  dec_mode;
    wire [1:0]  dec_len;
    wire        dec_store;
    wire        is_prefix;
    reg         store_q;

    function [15:0] sext8;
        input [7:0] b;
        begin
            sext8 = {{8{b[7]}}, b};
        end
    endfunction

    // Effective address of a memory operand from mode, index, stack pointer and operand.
    function [15:0] calc_ea;
        input [3:0]  m;
        input [15:0] opnd;
        input [15:0] ix;
        input [15:0] sp;
        begin
            case (m)
                `CBL_AM_DIR:  calc_ea = {8'h00, opnd[7:0]};
                `CBL_AM_EXT:  calc_ea = opnd;
                `CBL_AM_IX:   calc_ea = ix;
                `CBL_AM_IXP:  calc_ea = ix;
                `CBL_AM_IX1:  calc_ea = ix + {8'h00, opnd[7:0]};
                `CBL_AM_IX1P: calc_ea = ix + {8'h00, opnd[7:0]};
                `CBL_AM_IX2:  calc_ea = ix + opnd;
                `CBL_AM_SP1:  calc_ea = sp + {8'h00, opnd[7:0]};
                `CBL_AM_SP2:  calc_ea = sp + opnd;
                default:      calc_ea = opnd;
            endcase
        end
    endfunction

    assign is_prefix = (rdata_i == `CBL_PAGE2_PREFIX) && !pfx_q;

    cbl_mode_decode u_dec
    (
        .opcode_i   (rdata_i),
        .page2_i    (pfx_q),
        .mode_o     (dec_mode),
        .opnd_len_o (dec_len),
        .is_store_o (dec_store)
    );

    always @*
    begin
        state_d = state_q;
        case (state_q)
            ST_VEC_HI: state_d = ST_VEC_LO;
            ST_VEC_LO: state_d = ST_FREE;
            ST_FREE:   state_d = ST_FETCH0;
            ST_FETCH0: state_d = ST_OPCODE;
            ST_OPCODE:
            begin
                if (is_prefix)
                    state_d = ST_OPCODE;
                else if (dec_len != 2'h0)
                    state_d = ST_OPND;
                else
                    state_d = ST_EXEC;
            end
            ST_OPND:   state_d = (left_q == 2'h1) ? ST_EXEC : ST_OPND;
            ST_EXEC:
            begin
                if (mode_o == `CBL_AM_INH || mode_o == `CBL_AM_REL || mode_o == `CBL_AM_IMM)
                    state_d = ST_OPCODE;
                else
                    state_d = ST_DATA;
            end
            ST_DATA:   state_d = ST_OPCODE;
            default:   state_d = ST_VEC_HI;
        endcase
    end

    always @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            state_q      <= ST_VEC_HI;
            pc_o         <= `CBL_RESET_PC;
            sp_o         <= `CBL_RESET_SP;
            index_o      <= 16'h0000;
            opnd_q       <= 16'h0000;
            left_q       <= 2'h0;
            pfx_q        <= 1'b0;
            vec_q        <= 16'h0000;
            store_q      <= 1'b0;
            pop_pend_q   <= 1'b0;
            addr_o       <= {`CBL_VEC_PAGE, 8'h00};
            wdata_o      <= 8'h00;
            rd_o         <= 1'b0;
            wr_o         <= 1'b0;
            cyc_kind_o   <= `CBL_CYC_FREE;
            opcode_o     <= 8'h00;
            page2_o      <= 1'b0;
            mode_o       <= `CBL_AM_INH;
            ea_o         <= 16'h0000;
            pop_data_o   <= 8'h00;
            pop_valid_o  <= 1'b0;
            instr_done_o <= 1'b0;
        end
        else
        begin
            state_q      <= state_d;
            wr_o         <= 1'b0;
            rd_o         <= 1'b1;
            instr_done_o <= 1'b0;
            pop_valid_o  <= pop_pend_q;
            pop_pend_q   <= 1'b0;
            if (pop_pend_q)
                pop_data_o <= rdata_i;
            case (state_q)
                ST_VEC_HI:
                begin
                    // High byte first from the top page.
                    addr_o     <= {`CBL_VEC_PAGE, vec_lo_i};
                    cyc_kind_o <= `CBL_CYC_VECT;
                    vec_q      <= {8'h00, vec_lo_i + 8'h01};
                end
                ST_VEC_LO:
                begin
                    addr_o     <= {`CBL_VEC_PAGE, vec_q[7:0]};
                    cyc_kind_o <= `CBL_CYC_VECT;
                end
                ST_FREE:
                begin
                    // The vector low byte lands now; the bus idles one cycle before the first fetch.
                    pc_o[7:0]  <= rdata_i;
                    cyc_kind_o <= `CBL_CYC_FREE;
                end
                ST_FETCH0:
                begin
                    addr_o     <= pc_o;
                    cyc_kind_o <= `CBL_CYC_FETCH;
                end
                ST_OPCODE:
                begin
                    opcode_o   <= rdata_i;
                    pc_o       <= pc_o + 16'h0001;
                    addr_o     <= pc_o + 16'h0001;
                    // Without operands the bus idles, so the next opcode is fetched only once, by EXEC or, after a data cycle, by DATA.
                    cyc_kind_o <= (is_prefix || dec_len != 2'h0) ? `CBL_CYC_FETCH : `CBL_CYC_FREE;
                    if (is_prefix)
                        pfx_q <= 1'b1;
                    else
                    begin
                        pfx_q      <= 1'b0;
                        page2_o    <= pfx_q;
                        mode_o     <= dec_mode;
                        store_q    <= dec_store;
                        left_q     <= dec_len;
                        opnd_q     <= 16'h0000;
                    end
                end
                ST_OPND:
                begin
                    opnd_q     <= {opnd_q[7:0], rdata_i};
                    left_q     <= left_q - 2'h1;
                    pc_o       <= pc_o + 16'h0001;
                    addr_o     <= pc_o + 16'h0001;
                    cyc_kind_o <= (left_q == 2'h1) ? `CBL_CYC_FREE : `CBL_CYC_FETCH;
                end
                ST_EXEC:
                begin
                    ea_o    <= calc_ea(mode_o, opnd_q, index_o, sp_o);
                    if (mode_o == `CBL_AM_REL && take_branch_i)
                    begin
                        // The offset is applied to the address of the following instruction.
                        pc_o       <= pc_o + sext8(opnd_q[7:0]);
                        addr_o     <= pc_o + sext8(opnd_q[7:0]);
                        cyc_kind_o <= `CBL_CYC_FETCH;
                        instr_done_o <= 1'b1;
                    end
                    else if (mode_o == `CBL_AM_INH || mode_o == `CBL_AM_REL || mode_o == `CBL_AM_IMM)
                    begin
                        addr_o       <= pc_o;
                        cyc_kind_o   <= `CBL_CYC_FETCH;
                        instr_done_o <= 1'b1;
                        if (push_req_i)
                        begin
                            rd_o       <= 1'b0;
                            wr_o       <= 1'b1;
                            addr_o     <= sp_o;
                            wdata_o    <= push_data_i;
                            sp_o       <= sp_o - 16'h0001;
                            cyc_kind_o <= `CBL_CYC_PUSH;
                            state_q    <= ST_DATA;
                            instr_done_o <= 1'b0;
                        end
                        else if (pop_req_i)
                        begin
                            addr_o     <= sp_o + 16'h0001;
                            sp_o       <= sp_o + 16'h0001;
                            cyc_kind_o <= `CBL_CYC_POP;
                            pop_pend_q <= 1'b1;
                            state_q    <= ST_DATA;
                            instr_done_o <= 1'b0;
                        end
                    end
                    else
                    begin
                        addr_o <= calc_ea(mode_o, opnd_q, index_o, sp_o);
                        if (store_q)
                        begin
                            rd_o       <= 1'b0;
                            wr_o       <= 1'b1;
                            wdata_o    <= wr_data_i;
                            cyc_kind_o <= `CBL_CYC_WRITE;
                        end
                        else
                            cyc_kind_o <= `CBL_CYC_READ;
                        if (mode_o == `CBL_AM_IXP || mode_o == `CBL_AM_IX1P)
                            index_o <= index_o + 16'h0001;
                    end
                end
                ST_DATA:
                begin
                    addr_o       <= pc_o;
                    cyc_kind_o   <= `CBL_CYC_FETCH;
                    instr_done_o <= 1'b1;
                    if (!store_q && cyc_kind_o == `CBL_CYC_READ)
                    begin
                        pop_data_o  <= rdata_i;
                        pop_valid_o <= 1'b1;
                    end
                end
                default:
                begin
                    cyc_kind_o <= `CBL_CYC_FREE;
                end
            endcase
        end
    end
endmodule // cbl_bus_seq

// File: design/cbl_defs.vh
// Shared constants of the bus-cycle sequencer: cycle kinds, addressing modes, fixed opcodes.
// Assumes inclusion by bare name from the design modules.
`ifndef CBL_DEFS_VH
`define CBL_DEFS_VH
`define CBL_CYC_FREE     3'h0
`define CBL_CYC_FETCH    3'h1
`define CBL_CYC_READ     3'h2
`define CBL_CYC_WRITE    3'h3
`define CBL_CYC_PUSH     3'h4
`define CBL_CYC_POP      3'h5
`define CBL_CYC_VECT     3'h6
`define CBL_AM_INH       4'h0
`define CBL_AM_IMM       4'h1
`define CBL_AM_DIR       4'h2
`define CBL_AM_EXT       4'h3
`define CBL_AM_IX        4'h4
`define CBL_AM_IX1       4'h5
`define CBL_AM_IX2       4'h6
`define CBL_AM_IXP       4'h7
`define CBL_AM_IX1P      4'h8
`define CBL_AM_SP1       4'h9
`define CBL_AM_SP2       4'hA
`define CBL_AM_REL       4'hB
`define CBL_PAGE2_PREFIX 8'h9E
`define CBL_VEC_PAGE     8'hFF
`define CBL_RESET_PC     16'h0000
`define CBL_RESET_SP     16'h00FF
`endif

// File: design/cbl_mode_decode.v
// Opcode to addressing mode decoder for both opcode tables.
// Assumes a combinational caller that supplies the page-2 flag.
`timescale 1ns/1ps
`include "cbl_defs.vh"
module cbl_mode_decode
(
    input  wire [7:0] opcode_i,
    input  wire       page2_i,
    output reg  [3:0] mode_o,
    output reg  [1:0] opnd_len_o,
    output reg        is_store_o
);
    always @*
    begin
        mode_o     = `CBL_AM_INH;
        is_store_o = (opcode_i[3:0] == 4'h7) || (opcode_i[3:0] == 4'hF);
        if (page2_i)
        begin
            // Second table: columns 6, D, E and F act on the stack pointer; column C is 8-bit indexed.
            case (opcode_i[7:4])
                4'h6, 4'hE, 4'hF: mode_o = `CBL_AM_SP1;
                4'hD:             mode_o = `CBL_AM_SP2;
                4'hC:             mode_o = `CBL_AM_IX1;
                default:          mode_o = `CBL_AM_INH;
            endcase
        end
        else
        begin
            case (opcode_i[7:4])
                4'h0, 4'h1, 4'h3, 4'hB: mode_o = `CBL_AM_DIR;
                4'h2:                   mode_o = `CBL_AM_REL;
                4'h6:                   mode_o = (opcode_i[3:0] == 4'h1) ? `CBL_AM_IX1P : `CBL_AM_IX1;
                4'h7:                   mode_o = (opcode_i[3:0] == 4'h1) ? `CBL_AM_IXP : `CBL_AM_IX;
                4'hA:                   mode_o = `CBL_AM_IMM;
                4'hC:                   mode_o = `CBL_AM_EXT;
                4'hD:                   mode_o = `CBL_AM_IX2;
                4'hE:                   mode_o = `CBL_AM_IX1;
                4'hF:                   mode_o = `CBL_AM_IX;
                default:                mode_o = `CBL_AM_INH;
            endcase
        end
        case (mode_o)
            `CBL_AM_IMM, `CBL_AM_DIR, `CBL_AM_IX1, `CBL_AM_IX1P,
            `CBL_AM_SP1, `CBL_AM_REL:              opnd_len_o = 2'h1;
            `CBL_AM_EXT, `CBL_AM_IX2, `CBL_AM_SP2: opnd_len_o = 2'h2;
            default:                               opnd_len_o = 2'h0;
        endcase
    end
endmodule // cbl_mode_decode

// File: verif/cbl_bus_seq_sva.sv
// Checker for the bus-cycle sequencer: strobes, cycle kinds, vector and fetch order, index update.
// Assumes it is bound to cbl_bus_seq and sees only its ports.
`timescale 1ns/1ps
`include "cbl_defs.vh"
module cbl_bus_seq_sva
(
    input wire        clk_sys_i,
    input wire        srst_i,
    input wire [15:0] addr_o,
    input wire        rd_o,
    input wire        wr_o,
    input wire [2:0]  cyc_kind_o,
    input wire        page2_o,
    input wire [3:0]  mode_o,
    input wire [15:0] index_o,
    input wire        pop_valid_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    wire post_inc = (mode_o == `CBL_AM_IXP) || (mode_o == `CBL_AM_IX1P);
    chk_one_strobe: assert property (!$past(srst_i) |-> rd_o ^ wr_o)
        else $error("read and write strobes not exclusive");
    chk_free_read: assert property (cyc_kind_o == `CBL_CYC_FREE && !$past(srst_i) |-> rd_o && !wr_o)
        else $error("free cycle not shown as a read");
    chk_push_write: assert property (cyc_kind_o == `CBL_CYC_PUSH |-> wr_o && !rd_o)
        else $error("push cycle is not a write");
    chk_read_returns: assert property (
        rd_o && (cyc_kind_o == `CBL_CYC_POP || cyc_kind_o == `CBL_CYC_READ) |=> pop_valid_o)
        else $error("read byte not returned next cycle");
    chk_vect_page: assert property (cyc_kind_o == `CBL_CYC_VECT |-> rd_o && addr_o[15:8] == `CBL_VEC_PAGE)
        else $error("vector read off the top page");
    chk_vect_pair: assert property (
        cyc_kind_o == `CBL_CYC_VECT && $past(cyc_kind_o) != `CBL_CYC_VECT
        |=> cyc_kind_o == `CBL_CYC_VECT && addr_o == $past(addr_o) + 16'h0001)
        else $error("vector low byte does not follow high byte");
    chk_fetch_seq: assert property (
        cyc_kind_o == `CBL_CYC_FETCH && $past(cyc_kind_o) == `CBL_CYC_FETCH && !$past(srst_i)
        |-> addr_o == $past(addr_o) + 16'h0001)
        else $error("program fetch not sequential");
    chk_page2_sp: assert property (mode_o == `CBL_AM_SP1 || mode_o == `CBL_AM_SP2 |-> page2_o)
        else $error("stack mode decoded without page prefix");
    chk_post_inc: assert property (
        post_inc && (cyc_kind_o == `CBL_CYC_READ || cyc_kind_o == `CBL_CYC_WRITE)
        |-> index_o == $past(index_o) + 16'h0001)
        else $error("index not incremented after access");
endmodule // cbl_bus_seq_sva

bind cbl_bus_seq cbl_bus_seq_sva u_cbl_bus_seq_sva
(
    .clk_sys_i   (clk_sys_i),
    .srst_i      (srst_i),
    .addr_o      (addr_o),
    .rd_o        (rd_o),
    .wr_o        (wr_o),
    .cyc_kind_o  (cyc_kind_o),
    .page2_o     (page2_o),
    .mode_o      (mode_o),
    .index_o     (index_o),
    .pop_valid_o (pop_valid_o)
);

// File: verif/cbl_mem_model.sv
// Single-cycle program and data memory on the far side of the sequencer.
// Assumes a read is answered within its own cycle, before the edge that ends it.
`timescale 1ns/1ps
module cbl_mem_model
(
    input  wire        clk_sys_i,
    input  wire [15:0] addr_i,
    input  wire        rd_i,
    input  wire        wr_i,
    input  wire [7:0]  wdata_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [0:65535];
    initial begin
        for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ 8'h5A;
        rdata_o = 8'h00;
    end
    // Outside a read the data lines toggle, so a stale byte never looks like an answer.
    always @(posedge clk_sys_i) begin
        if (wr_i) mem[addr_i] <= wdata_i;
    end
    // Reads are served mid-cycle so the byte stands settled at the edge that ends the cycle.
    always @(negedge clk_sys_i) begin
        rdata_o <= rd_i ? mem[addr_i] : ~rdata_o;
    end
endmodule // cbl_mem_model

// File: verif/testbench.sv
// Self-checking bench: runs a small program through the sequencer and judges its bus cycles.
// Assumes the memory model answers every read mid-cycle, before the following rising edge.
`timescale 1ns/1ps
`include "cbl_defs.vh"
`define CBL_CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin err_total++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module testbench;
    typedef struct packed {logic [2:0] k; logic [15:0] a; logic [7:0] d; logic [3:0] m;} cbl_cyc_t;
    logic        clk_sys_i, srst_i, push_req_i, pop_req_i, take_branch_i, irq_i;
    logic [7:0]  push_data_i, wr_data_i, vec_lo_i, last_pop;
    logic [15:0] ix, sp0;
    wire  [7:0]  rdata_i, wdata_o, pop_data_o, opcode_o;
    wire  [15:0] addr_o, index_o, sp_o, ea_o, pc_o;
    wire  [2:0]  cyc_kind_o;
    wire  [3:0]  mode_o;
    wire         rd_o, wr_o, pop_valid_o, instr_done_o;
    int          err_total, n_checks, s;
    cbl_cyc_t    lg[$];
    logic [7:0]  prog [26] = '{8'hC6, 8'h00, 8'hC4, 8'hC7, 8'h00, 8'hC8, 8'h9D, 8'h9D, 8'hF6, 8'hE6,
        8'h05, 8'hD6, 8'h01, 8'h00, 8'h9E, 8'hE6, 8'h03, 8'h9E, 8'hD6, 8'h00, 8'h02, 8'h71,
        8'h61, 8'h02, 8'h20, 8'hEF};
    cbl_bus_seq u_cbl_bus_seq (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .rdata_i(rdata_i), .irq_i(irq_i),
        .vec_lo_i(vec_lo_i), .push_req_i(push_req_i), .pop_req_i(pop_req_i), .push_data_i(push_data_i),
        .wr_data_i(wr_data_i), .take_branch_i(take_branch_i), .addr_o(addr_o), .wdata_o(wdata_o),
        .rd_o(rd_o), .wr_o(wr_o), .cyc_kind_o(cyc_kind_o), .opcode_o(opcode_o), .page2_o(), .mode_o(mode_o),
        .ea_o(ea_o), .pc_o(pc_o), .index_o(index_o), .sp_o(sp_o), .pop_data_o(pop_data_o),
        .pop_valid_o(pop_valid_o), .instr_done_o(instr_done_o));
    cbl_mem_model u_cbl_mem_model (.clk_sys_i(clk_sys_i), .addr_i(addr_o), .rd_i(rd_o), .wr_i(wr_o),
        .wdata_i(wdata_o), .rdata_o(rdata_i));
    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    function automatic cbl_cyc_t cur();
        return '{cyc_kind_o, addr_o, wdata_o, mode_o};
    endfunction
    function automatic int find(logic [2:0] k, int st);
        for (int i = st; i < lg.size(); i++) if (lg[i].k === k) return i;
        return -1;
    endfunction
    always @(posedge clk_sys_i) if (rd_o | wr_o) lg.push_back(cur());
    task automatic wait_done();
        int n;
        n = 0;
        do begin
            @(negedge clk_sys_i);
            n++;
            if (pop_valid_o === 1'b1) last_pop = pop_data_o;
        end while (instr_done_o !== 1'b1 && n < 40);
        `CBL_CHK("instr_done", 1'b1, instr_done_o)
        lg.push_back(cur());
    endtask
    task automatic one(input string nm, input logic [2:0] k, input logic [15:0] a, input logic [3:0] m,
        input bit keep);
        int i;
        if (!keep) lg.delete();
        wait_done();
        i = find(k, 0);
        `CBL_CHK(nm, a, (i < 0) ? 16'hXXXX : lg[i].a)
        `CBL_CHK(nm, m, (i < 0) ? 4'hX : lg[i].m)
    endtask
    task automatic t_reset();
        srst_i = 1'b1;
        repeat (6) @(negedge clk_sys_i);
        srst_i = 1'b0;
        lg.delete();
        repeat (5) @(negedge clk_sys_i);
        `CBL_CHK("vec_hi", {`CBL_CYC_VECT, 16'hFFFE}, {lg[0].k, lg[0].a})
        `CBL_CHK("vec_lo", {`CBL_CYC_VECT, 16'hFFFF}, {lg[1].k, lg[1].a})
        `CBL_CHK("free", `CBL_CYC_FREE, lg[2].k)
        `CBL_CHK("fetch0", {`CBL_CYC_FETCH, 16'h0010}, {lg[3].k, lg[3].a})
        repeat (3) void'(lg.pop_front());
        $display("test reset done");
    endtask
    task automatic t_ext();
        one("ext_read", `CBL_CYC_READ, 16'h00C4, `CBL_AM_EXT, 1'b1);
        `CBL_CHK("fetch_seq", {16'h0010, 16'h0011, 16'h0012}, {lg[0].a, lg[1].a, lg[2].a})
        `CBL_CHK("read_data", 8'h9E, last_pop)
        `CBL_CHK("ea", 16'h00C4, ea_o)
        `CBL_CHK("opcode", 8'hC6, opcode_o)
        wr_data_i = 8'h3C;
        one("ext_write", `CBL_CYC_WRITE, 16'h00C8, `CBL_AM_EXT, 1'b0);
        `CBL_CHK("wdata", 8'h3C, lg[find(`CBL_CYC_WRITE, 0)].d)
        @(negedge clk_sys_i);
        `CBL_CHK("stored", 8'h3C, u_cbl_mem_model.mem[16'h00C8])
        $display("test extended done");
    endtask
    task automatic t_stack();
        sp0 = sp_o;
        push_req_i = 1'b1;
        push_data_i = 8'hA7;
        one("push", `CBL_CYC_PUSH, sp0, `CBL_AM_INH, 1'b0);
        `CBL_CHK("push_data", 8'hA7, lg[find(`CBL_CYC_PUSH, 0)].d)
        push_req_i = 1'b0;
        pop_req_i = 1'b1;
        last_pop = 8'h00;
        one("pop", `CBL_CYC_POP, sp0, `CBL_AM_INH, 1'b0);
        pop_req_i = 1'b0;
        `CBL_CHK("pop_data", 8'hA7, last_pop)
        $display("test stack done");
    endtask
    task automatic t_modes();
        ix = index_o;
        sp0 = sp_o;
        one("ix0", `CBL_CYC_READ, ix, `CBL_AM_IX, 1'b0);
        one("ix8", `CBL_CYC_READ, ix + 16'h0005, `CBL_AM_IX1, 1'b0);
        one("ix16", `CBL_CYC_READ, ix + 16'h0100, `CBL_AM_IX2, 1'b0);
        one("sp8", `CBL_CYC_READ, sp0 + 16'h0003, `CBL_AM_SP1, 1'b0);
        one("sp16", `CBL_CYC_READ, sp0 + 16'h0002, `CBL_AM_SP2, 1'b0);
        one("ixp", `CBL_CYC_READ, ix, `CBL_AM_IXP, 1'b0);
        `CBL_CHK("ixp_inc", ix + 16'h0001, index_o)
        one("ix1p", `CBL_CYC_READ, ix + 16'h0003, `CBL_AM_IX1P, 1'b0);
        `CBL_CHK("ix1p_inc", ix + 16'h0002, index_o)
        $display("test modes done");
    endtask
    task automatic t_branch();
        take_branch_i = 1'b1;
        lg.delete();
        wait_done();
        take_branch_i = 1'b0;
        `CBL_CHK("pc", 16'h0019, pc_o)
        s = lg.size() - 1;
        wait_done();
        `CBL_CHK("target", 16'h0019, lg[find(`CBL_CYC_FETCH, s)].a)
        $display("test branch done");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // The program needs about 65 cycles, so 1000 leaves ample margin.
    initial begin
        repeat (1000) @(posedge clk_sys_i);
        err_total++;
        $display("CHECK FAILED watchdog expected finish seen timeout");
        close_out();
    end
    initial begin
        {srst_i, push_req_i, pop_req_i, take_branch_i, irq_i} = 5'h10;
        {push_data_i, wr_data_i, last_pop} = 24'h000000;
        vec_lo_i = 8'hFE;
        err_total = 0;
        n_checks = 0;
        #1;
        u_cbl_mem_model.mem[16'hFFFF] = 8'h10;
        foreach (prog[i]) u_cbl_mem_model.mem[16'h0010 + i] = prog[i];
        t_reset();
        t_ext();
        t_stack();
        t_modes();
        t_branch();
        close_out();
    end
endmodule // testbench
